// *** verilog/disp_regs.svh ***
// constants shared by both ends of the four-character display link
`ifndef DISP_REGS_SVH
`define DISP_REGS_SVH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define CLK_MHZ 250

// ----------------------------------------------------------------------
// host-side register offsets (byte addresses on apb)
// ----------------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_CMD 12'h004
`define OFS_STAT 12'h008

// ----------------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------------
`define CTRL_OVERLAY_BIT 0
`define CTRL_WIPE_N_BIT 1
`define CTRL_DARKEN_N_BIT 2
`define CTRL_RESET 32'h0000_0006

// ----------------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------------
`define CMD_CODE_LSB 0
`define CMD_CODE_MSB 6
`define CMD_DIGIT_LSB 7
`define CMD_DIGIT_MSB 8
`define CMD_TARGET_BIT 9

// status register fields
`define STAT_BUSY_BIT 0

// ----------------------------------------------------------------------
// write cycle timing, in ns, and cycles derived from it (rounded up)
// ----------------------------------------------------------------------
`define T_SETUP_NS 150
`define T_WRITE_NS 130
`define T_HOLD_NS 50
`define T_SETUP_CYC ((`T_SETUP_NS * `CLK_MHZ + 999) / 1000)
`define T_WRITE_CYC ((`T_WRITE_NS * `CLK_MHZ + 999) / 1000)
`define T_HOLD_CYC ((`T_HOLD_NS * `CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------------
// clear time and scan timing
// ----------------------------------------------------------------------
`define T_CLEAR_US 4000
`define T_CLEAR_CYC (`T_CLEAR_US * `CLK_MHZ)
`define SCAN_POSITIONS 4
`define T_SCAN_STEP_CYC (`T_CLEAR_CYC / `SCAN_POSITIONS)

`endif

// *** verilog/disp_pkg.sv ***
// types shared by both ends of the four-character display link
package disp_pkg;
    typedef logic [6:0] char_t;
    typedef logic [1:0] digit_t;
    typedef enum logic [1:0] {
        HOST_IDLE,
        HOST_SETUP,
        HOST_STROBE,
        HOST_HOLD
    } host_state_t;
endpackage

// *** verilog/disp_link_if.sv ***
// parallel write link between host logic and the display end
`timescale 1ns/1ns
`default_nettype none
interface disp_link_if;
    logic gate_one_n;
    logic gate_two_n;
    logic write_strobe_n;
    logic target_pick_n;
    logic digit_select_hi;
    logic digit_select_lo;
    logic [6:0] char_code;
    logic overlay_show;
    logic memory_wipe_n;
    logic darken_n;

    modport host (
        output gate_one_n, gate_two_n, write_strobe_n, target_pick_n,
        output digit_select_hi, digit_select_lo, char_code,
        output overlay_show, memory_wipe_n, darken_n
    );
    modport display (
        input gate_one_n, gate_two_n, write_strobe_n, target_pick_n,
        input digit_select_hi, digit_select_lo, char_code,
        input overlay_show, memory_wipe_n, darken_n
    );
endinterface
`default_nettype wire

// *** verilog/display_end.sv ***
// display end: character and cursor memories, clear, blank and scan
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "disp_regs.svh"
module display_end #(
    parameter int CLEAR_CYCLES = `T_CLEAR_CYC,
    parameter int SCAN_STEP_CYCLES = `T_SCAN_STEP_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // link from the host
    disp_link_if.display link,
    // digit and segment drive
    output logic [3:0] char_position,
    output disp_pkg::char_t shown_code,
    output logic shown_valid,
    output logic [15:0] cursor_segments,
    output logic decimal_point
);
    import disp_pkg::*;

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    logic write_on;
    logic char_write;
    logic cursor_write;
    digit_t wr_index;
    char_t wr_code;

    // both gates low and strobe low; otherwise no character or cursor write happens
    assign write_on = !link.gate_one_n && !link.gate_two_n
        && !link.write_strobe_n;
    assign char_write = write_on && link.target_pick_n;
    assign cursor_write = write_on && !link.target_pick_n;
    // index zero is the rightmost position
    assign wr_index = {link.digit_select_hi, link.digit_select_lo};
    // codes with bit 6 equal to bit 5 have no glyph; store a blank
    assign wr_code = (link.char_code[6] == link.char_code[5]) ?
        7'h00 : link.char_code;

    // ------------------------------------------------------------------
    // clear timer
    // ------------------------------------------------------------------
    // the timer restarts on every character write, so the last write
    // before the wipe is only lost once a full clear time has passed
    logic [31:0] wipe_cnt_reg;
    logic [31:0] wipe_cnt_next;
    logic wipe_active;

    always_comb begin
        wipe_cnt_next = wipe_cnt_reg;
        if (link.memory_wipe_n || !link.darken_n) begin
            wipe_cnt_next = 32'h0000_0000;
        end else if (char_write) begin
            wipe_cnt_next = 32'h0000_0000;
        end else if (wipe_cnt_reg < 32'(CLEAR_CYCLES)) begin
            wipe_cnt_next = wipe_cnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wipe_cnt_reg <= 32'h0000_0000;
        end else begin
            wipe_cnt_reg <= wipe_cnt_next;
        end
    end

    // no gate term here: the wipe runs whatever the gates do
    assign wipe_active = (wipe_cnt_reg >= 32'(CLEAR_CYCLES))
        && !link.memory_wipe_n && link.darken_n;

    // ------------------------------------------------------------------
    // character and cursor memories
    // ------------------------------------------------------------------
    char_t char_mem_reg [4];
    char_t char_mem_next [4];
    logic [3:0] cursor_reg;
    logic [3:0] cursor_next;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            char_mem_next[i] = char_mem_reg[i];
        end
        cursor_next = cursor_reg;
        if (wipe_active) begin
            for (int i = 0; i < 4; i++) begin
                char_mem_next[i] = 7'h00;
            end
        end else if (char_write) begin
            // all seven code bits land in the addressed word
            char_mem_next[wr_index] = wr_code;
        end
        // cursor flags stay apart from the wipe and the darken input
        if (cursor_write) begin
            cursor_next[wr_index] = link.char_code[0];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                char_mem_reg[i] <= 7'h00;
            end
            cursor_reg <= 4'h0;
        end else begin
            // writes complete whatever the darken input shows
            for (int i = 0; i < 4; i++) begin
                char_mem_reg[i] <= char_mem_next[i];
            end
            cursor_reg <= cursor_next;
        end
    end

    // ------------------------------------------------------------------
    // scan divider and modulo-four counter
    // ------------------------------------------------------------------
    logic [31:0] step_cnt_reg;
    logic [31:0] step_cnt_next;
    logic step_tick;
    digit_t scan_reg;
    digit_t scan_next;

    assign step_tick = (step_cnt_reg >= 32'(SCAN_STEP_CYCLES - 1));

    always_comb begin
        step_cnt_next = step_cnt_reg + 32'h0000_0001;
        scan_next = scan_reg;
        if (!link.darken_n) begin
            step_cnt_next = 32'h0000_0000;
            scan_next = 2'h0;
        end else if (step_tick) begin
            step_cnt_next = 32'h0000_0000;
            scan_next = scan_reg + 2'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            step_cnt_reg <= 32'h0000_0000;
            scan_reg <= 2'h0;
        end else begin
            step_cnt_reg <= step_cnt_next;
            scan_reg <= scan_next;
        end
    end

    // ------------------------------------------------------------------
    // display drive
    // ------------------------------------------------------------------
    // the font itself lives outside; this end hands out the scanned
    // code, or the all-on cursor glyph, one position at a time
    logic [3:0] pos_next;
    char_t code_next;
    logic valid_next;
    logic [15:0] cseg_next;
    logic dp_next;
    logic show_cursor;

    // overlay only picks what is shown, never the stored flags
    assign show_cursor = link.overlay_show && cursor_reg[scan_reg];

    always_comb begin
        pos_next = 4'h0;
        code_next = 7'h00;
        valid_next = 1'b0;
        cseg_next = 16'h0000;
        dp_next = 1'b0;
        if (link.darken_n) begin
            pos_next = 4'h1 << scan_reg;
            if (show_cursor) begin
                cseg_next = 16'hffff;
                dp_next = 1'b1;
            end else begin
                code_next = char_mem_reg[scan_reg];
                valid_next = char_mem_reg[scan_reg][6]
                    != char_mem_reg[scan_reg][5];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            char_position <= 4'h0;
            shown_code <= 7'h00;
            shown_valid <= 1'b0;
            cursor_segments <= 16'h0000;
            decimal_point <= 1'b0;
        end else begin
            char_position <= pos_next;
            shown_code <= code_next;
            shown_valid <= valid_next;
            cursor_segments <= cseg_next;
            decimal_point <= dp_next;
        end
    end
endmodule // display_end
`default_nettype wire

// *** verilog/host_end.sv ***
// host end: apb-controlled driver of the display write link
`timescale 1ns/1ns
`default_nettype none
`include "disp_regs.svh"
module host_end (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link to the display
    disp_link_if.host link
);
    import disp_pkg::*;

    localparam logic [7:0] SETUP_CYC = 8'(`T_SETUP_CYC);
    localparam logic [7:0] WRITE_CYC = 8'(`T_WRITE_CYC);
    localparam logic [7:0] HOLD_CYC = 8'(`T_HOLD_CYC);

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic access;
    logic hit_ctrl;
    logic hit_cmd;
    logic hit_stat;
    logic busy;
    logic cmd_take;

    assign access = psel && penable;
    assign hit_ctrl = paddr == `OFS_CTRL;
    assign hit_cmd = paddr == `OFS_CMD;
    assign hit_stat = paddr == `OFS_STAT;
    // a command write waits while a write cycle is still running
    assign pready = !(hit_cmd && pwrite && busy);
    assign pslverr = !(hit_ctrl || hit_cmd || hit_stat);
    assign cmd_take = access && pready && pwrite && hit_cmd;

    // ------------------------------------------------------------------
    // registers and write-cycle sequencer
    // ------------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [9:0] cmd_reg;
    logic [9:0] cmd_next;
    host_state_t state_reg;
    host_state_t state_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [31:0] rdata_next;

    assign busy = state_reg != HOST_IDLE;

    always_comb begin
        ctrl_next = ctrl_reg;
        cmd_next = cmd_reg;
        state_next = state_reg;
        cnt_next = cnt_reg - 8'h01;
        rdata_next = 32'h0000_0000;
        if (access && pwrite && hit_ctrl) begin
            ctrl_next = {29'h0, pwdata[2:0]};
        end
        if (!pwrite && hit_ctrl) begin
            rdata_next = ctrl_reg;
        end else if (!pwrite && hit_cmd) begin
            rdata_next = {22'h0, cmd_reg};
        end else if (!pwrite && hit_stat) begin
            rdata_next = {31'h0, busy};
        end
        case (state_reg)
            HOST_IDLE: begin
                cnt_next = SETUP_CYC;
                if (cmd_take) begin
                    cmd_next = pwdata[9:0];
                    state_next = HOST_SETUP;
                end
            end
            HOST_SETUP: begin
                if (cnt_reg <= 8'h01) begin
                    cnt_next = WRITE_CYC;
                    state_next = HOST_STROBE;
                end
            end
            HOST_STROBE: begin
                if (cnt_reg <= 8'h01) begin
                    cnt_next = HOLD_CYC;
                    state_next = HOST_HOLD;
                end
            end
            HOST_HOLD: begin
                if (cnt_reg <= 8'h01) begin
                    state_next = HOST_IDLE;
                end
            end
            default: begin
                state_next = HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= `CTRL_RESET;
            cmd_reg <= 10'h200;
            state_reg <= HOST_IDLE;
            cnt_reg <= 8'h00;
            prdata <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            cmd_reg <= cmd_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            prdata <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // link drive
    // ------------------------------------------------------------------
    // address, data and target come straight from the held command, so
    // they stand unchanged across setup, strobe and hold
    assign link.gate_one_n = !busy;
    assign link.gate_two_n = !busy;
    assign link.write_strobe_n = state_reg != HOST_STROBE;
    assign link.target_pick_n = cmd_reg[`CMD_TARGET_BIT];
    assign link.digit_select_hi = cmd_reg[`CMD_DIGIT_MSB];
    assign link.digit_select_lo = cmd_reg[`CMD_DIGIT_LSB];
    assign link.char_code = cmd_reg[`CMD_CODE_MSB:`CMD_CODE_LSB];
    assign link.overlay_show = ctrl_reg[`CTRL_OVERLAY_BIT];
    // software keeps wipe low 4 ms after the last write; darken is a
    // level, not meant for dimming
    assign link.memory_wipe_n = ctrl_reg[`CTRL_WIPE_N_BIT];
    assign link.darken_n = ctrl_reg[`CTRL_DARKEN_N_BIT];
endmodule // host_end
`default_nettype wire

// *** verification/four_char_display_write_port_monitor.sv ***
// concurrent checks on the display write link and the display outputs
`timescale 1ns/1ns
`default_nettype none
`include "disp_regs.svh"
module four_char_display_write_port_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // link signals
    input wire logic gate_one_n,
    input wire logic gate_two_n,
    input wire logic write_strobe_n,
    input wire logic target_pick_n,
    input wire logic digit_select_hi,
    input wire logic digit_select_lo,
    input wire logic [6:0] char_code,
    input wire logic overlay_show,
    input wire logic memory_wipe_n,
    input wire logic darken_n,
    // display outputs
    input wire logic [3:0] char_position,
    input wire logic [6:0] shown_code,
    input wire logic shown_valid,
    input wire logic [15:0] cursor_segments,
    input wire logic decimal_point
);
    // ------------------------------------------------------------------
    // strobe width counter
    // ------------------------------------------------------------------
    logic [7:0] strobe_cnt_reg;
    logic [7:0] strobe_cnt_next;
    always_comb begin
        strobe_cnt_next = write_strobe_n ? 8'h00 : strobe_cnt_reg + 8'h01;
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            strobe_cnt_reg <= 8'h00;
        end else begin
            strobe_cnt_reg <= strobe_cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_strobe_gated: assert property (
        !write_strobe_n |-> !gate_one_n && !gate_two_n)
        else $error("strobe low without both gates low");
    a_strobe_length: assert property (
        $rose(write_strobe_n) |-> strobe_cnt_reg >= 8'(`T_WRITE_CYC))
        else $error("write strobe shorter than the write time");
    a_fields_steady: assert property (
        !write_strobe_n && $past(!write_strobe_n) |-> $stable({gate_one_n,
        gate_two_n, target_pick_n, digit_select_hi, digit_select_lo,
        char_code})) else $error("link fields moved during strobe");
    a_hold_after: assert property (
        $rose(write_strobe_n) |-> !gate_one_n && !gate_two_n &&
        $stable({target_pick_n, digit_select_hi, digit_select_lo, char_code}))
        else $error("link fields released with the strobe");
    a_dark_output: assert property (
        !darken_n |=> char_position == 4'h0 && !shown_valid &&
        cursor_segments == 16'h0) else $error("display lit while dark");
    a_scan_restart: assert property (
        $rose(darken_n) |-> ##[1:3] char_position == 4'h1)
        else $error("scan did not restart at the rightmost position");
    a_scan_rotates: assert property (
        char_position != $past(char_position) && char_position != 4'h0 &&
        $past(char_position) != 4'h0 |-> char_position ==
        {$past(char_position[2:0]), $past(char_position[3])})
        else $error("scan left the modulo four order");
    a_scan_onehot: assert property ($onehot0(char_position))
        else $error("more than one digit enabled");
    a_cursor_glyph: assert property (
        cursor_segments != 16'h0 |-> cursor_segments == 16'hffff &&
        decimal_point && shown_code == 7'h00)
        else $error("cursor glyph incomplete");
    a_overlay_off: assert property (
        !overlay_show |=> cursor_segments == 16'h0 && !decimal_point)
        else $error("cursor shown with overlay low");
    a_blank_codes: assert property (
        shown_valid |-> shown_code[6] != shown_code[5])
        else $error("glyph shown for a blank code");

    c_cursor_shown: cover property (cursor_segments == 16'hffff);
    c_cursor_write: cover property (!write_strobe_n && !target_pick_n);
    c_wipe_held: cover property (!memory_wipe_n && darken_n);
    c_dark_entered: cover property ($fell(darken_n));
endmodule // four_char_display_write_port_monitor
`default_nettype wire

// *** verification/four_char_display_write_port_tb_top.sv ***
// self-checking bench joining the host end and the display end
`timescale 1ns/1ns
`default_nettype none
`include "disp_regs.svh"
module four_char_display_write_port_tb_top;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] char_position;
    logic [6:0] shown_code;
    logic shown_valid;
    logic [15:0] cursor_segments;
    logic decimal_point;
    logic [31:0] rd;
    logic er;
    logic [6:0] mem [4];
    int num_errors = 0;
    int checked = 0;

    disp_link_if link_bus ();
    always #2 ref_clk = ~ref_clk;

    host_end u_host_end (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_bus));
    // short clear and scan counts keep the run brief
    display_end #(.CLEAR_CYCLES(40), .SCAN_STEP_CYCLES(4)) u_display_end (
        .ref_clk(ref_clk), .resetn(resetn), .link(link_bus),
        .char_position(char_position), .shown_code(shown_code),
        .shown_valid(shown_valid), .cursor_segments(cursor_segments),
        .decimal_point(decimal_point));
    four_char_display_write_port_monitor u_four_char_display_write_port_monitor (
        .ref_clk(ref_clk), .resetn(resetn),
        .gate_one_n(link_bus.gate_one_n), .gate_two_n(link_bus.gate_two_n),
        .write_strobe_n(link_bus.write_strobe_n),
        .target_pick_n(link_bus.target_pick_n),
        .digit_select_hi(link_bus.digit_select_hi),
        .digit_select_lo(link_bus.digit_select_lo),
        .char_code(link_bus.char_code), .overlay_show(link_bus.overlay_show),
        .memory_wipe_n(link_bus.memory_wipe_n), .darken_n(link_bus.darken_n),
        .char_position(char_position), .shown_code(shown_code),
        .shown_valid(shown_valid), .cursor_segments(cursor_segments),
        .decimal_point(decimal_point));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("counts: checked=%0d errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // the request stands until pready is seen high at a rising edge; the
    // answer is taken at that same edge, before the edge's updates land
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cmd(input logic t, input logic [1:0] dg,
            input logic [6:0] c);
        int n;
        apb(1'b1, `OFS_CMD, {22'h0, t, dg, c});
        n = 0;
        do begin
            apb(1'b0, `OFS_STAT, 32'h0);
            n++;
        end while (rd[`STAT_BUSY_BIT] !== 1'b0 && n < 200);
        // a write cycle that never ends counts as a mismatch
        chk({31'h0, rd[`STAT_BUSY_BIT]}, 32'h0);
        if (t) mem[dg] = (c[6] == c[5]) ? 7'h00 : c;
    endtask

    task automatic show(input int p, input logic cur);
        int n;
        logic [6:0] e;
        e = mem[p];
        n = 0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        while (char_position !== (4'h1 << p) && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        if (cur) begin
            chk({3'h0, char_position, cursor_segments, decimal_point,
                shown_code, shown_valid}, {3'h0, 4'h1 << p, 16'hffff, 1'b1,
                7'h00, 1'b0});
        end else begin
            chk({3'h0, char_position, cursor_segments, decimal_point,
                shown_code, shown_valid}, {3'h0, 4'h1 << p, 16'h0, 1'b0,
                e, e[6] != e[5]});
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk(rd, `CTRL_RESET);
        chk({31'h0, er}, 32'h0);
        apb(1'b1, 12'h00c, 32'h0000_00ff);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        $display("test regs done");
    endtask

    task automatic t_chars;
        cmd(1'b1, 2'h2, 7'h41);
        cmd(1'b1, 2'h0, 7'h35);
        cmd(1'b1, 2'h3, 7'h7f);
        cmd(1'b1, 2'h1, 7'h5a);
        apb(1'b0, `OFS_CMD, 32'h0);
        chk(rd, 32'h0000_02da);
        for (int p = 0; p < 4; p++) show(p, 1'b0);
        $display("test chars done");
    endtask

    task automatic t_cursor;
        cmd(1'b0, 2'h1, 7'h01);
        show(1, 1'b0);
        apb(1'b1, `OFS_CTRL, 32'h7);
        show(1, 1'b1);
        show(0, 1'b0);
        apb(1'b1, `OFS_CTRL, 32'h6);
        apb(1'b1, `OFS_CTRL, 32'h7);
        show(1, 1'b1);
        cmd(1'b0, 2'h1, 7'h7e);
        show(1, 1'b0);
        apb(1'b1, `OFS_CTRL, 32'h6);
        $display("test cursor done");
    endtask

    task automatic t_dark;
        apb(1'b1, `OFS_CTRL, 32'h2);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({28'h0, char_position}, 32'h0);
        cmd(1'b1, 2'h0, 7'h42);
        apb(1'b1, `OFS_CTRL, 32'h0);
        repeat (60) @(posedge ref_clk);
        apb(1'b1, `OFS_CTRL, 32'h6);
        show(0, 1'b0);
        $display("test dark done");
    endtask

    task automatic t_wipe;
        cmd(1'b0, 2'h3, 7'h01);
        apb(1'b1, `OFS_CTRL, 32'h4);
        cmd(1'b0, 2'h2, 7'h01);
        repeat (60) @(posedge ref_clk);
        apb(1'b1, `OFS_CTRL, 32'h6);
        for (int p = 0; p < 4; p++) mem[p] = 7'h00;
        for (int p = 0; p < 4; p++) show(p, 1'b0);
        apb(1'b1, `OFS_CTRL, 32'h7);
        show(3, 1'b1);
        show(2, 1'b1);
        show(0, 1'b0);
        apb(1'b1, `OFS_CTRL, 32'h6);
        $display("test wipe done");
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        t_regs();
        t_chars();
        t_cursor();
        t_dark();
        t_wipe();
        finish_test();
    end

    // nine commands of about a hundred cycles, with wide margin
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        finish_test();
    end
endmodule // four_char_display_write_port_tb_top
`default_nettype wire
